/* core/hppad_autodetect.sv */
// host port protocol autodetector and shared pin mux
// assumes the I2C, SPI and UART engines sit on ref_clk_i beside it;
// each shared pin is given as input, output and output enable
`default_nettype none

module hppad_autodetect #(
    parameter int unsigned SETTLE_CYCLES = hppad_pkg::SETTLE_CYC
) (
    // clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    // restart detection after wake from sleep, same domain pulse
    input wire logic wake_i,
    // shared clock pin
    input wire logic shared_clock_pin_i,
    output logic shared_clock_pin_o,
    output logic shared_clock_pin_oe_o,
    // shared host in pin
    input wire logic shared_host_in_pin_i,
    output logic shared_host_in_pin_o,
    output logic shared_host_in_pin_oe_o,
    // shared host out pin
    input wire logic shared_host_out_pin_i,
    output logic shared_host_out_pin_o,
    output logic shared_host_out_pin_oe_o,
    // shared select / receive pin
    input wire logic shared_select_pin_i,
    output logic shared_select_pin_o,
    output logic shared_select_pin_oe_o,
    // detected protocol, read only
    output hppad_pkg::hppad_sel_t protocol_select_o,
    // SPI engine side
    output logic spi_sclk_o,
    output logic spi_mosi_o,
    output logic spi_cs_b_o,
    input wire logic spi_miso_i,
    // UART engine side
    output logic uart_rxd_o,
    output logic uart_cts_b_o,
    input wire logic uart_txd_i,
    input wire logic uart_rts_b_i,
    // I2C engine side
    output logic i2c_scl_o,
    output logic i2c_sda_o,
    output logic [6:0] i2c_addr_o,
    input wire logic i2c_sda_low_i
);
    import hppad_pkg::*;

    localparam logic [SETTLE_W-1:0] SETTLE_LAST =
        SETTLE_W'(SETTLE_CYCLES - 1);

    hppad_state_e state_q, state_d;
    hppad_sel_t sel_q, sel_d;
    logic [SETTLE_W-1:0] settle_q;
    logic [WIN_W-1:0] win_q;
    logic [EDGE_W-1:0] edges_q;
    logic [PIN_N-1:0] meta_q, sync_q, prev_q;

    // two flip-flop synchroniser; meta_q feeds sync_q alone
    wire logic [PIN_N-1:0] pins_raw = {shared_select_pin_i,
        shared_host_out_pin_i, shared_host_in_pin_i, shared_clock_pin_i};

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_q <= PIN_IDLE;
            sync_q <= PIN_IDLE;
            prev_q <= PIN_IDLE;
        end else if (clk_en_i) begin
            meta_q <= pins_raw;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // start patterns, looked at only after the sampled history
    wire logic scl_s = sync_q[PIN_CLK];
    wire logic sda_s = sync_q[PIN_HOUT];
    wire logic i2c_start = scl_s && prev_q[PIN_CLK] && // [R7]
        prev_q[PIN_HOUT] && !sda_s;
    wire logic sel_fall = prev_q[PIN_SEL] && !sync_q[PIN_SEL]; // [R8]
    wire logic clk_edge = sync_q[PIN_CLK] ^ prev_q[PIN_CLK]; // [R9]

    wire logic settle_done = (settle_q == SETTLE_LAST); // [R6]
    wire logic win_end = (win_q == WIN_LAST); // [R9] [R16]
    wire logic is_spi = (edges_q >= EDGE_SPI_MIN); // [R10]
    wire logic is_uart = (edges_q == EDGE_NONE); // [R11]

    // detector; wake restarts settling, else a lock holds
    always_comb begin
        state_d = state_q;
        sel_d = sel_q;
        unique case (state_q)
            HPPAD_SETTLE: begin
                sel_d = SEL_NONE;
                if (settle_done) begin
                    state_d = HPPAD_WATCH; // [R6]
                end
            end
            HPPAD_WATCH: begin
                if (i2c_start) begin
                    state_d = HPPAD_LOCKED;
                    sel_d = SEL_I2C; // [R7] [R3]
                end else if (sel_fall) begin
                    state_d = HPPAD_WINDOW; // [R8]
                end
            end
            HPPAD_WINDOW: begin
                if (win_end) begin
                    if (is_spi) begin
                        state_d = HPPAD_LOCKED;
                        sel_d = SEL_SPI; // [R10] [R3]
                    end else if (is_uart) begin
                        state_d = HPPAD_LOCKED;
                        sel_d = SEL_UART; // [R11] [R3]
                    end else begin
                        state_d = HPPAD_WATCH; // [R17]
                        sel_d = SEL_NONE;
                    end
                end
            end
            HPPAD_LOCKED: begin
                state_d = HPPAD_LOCKED; // [R18]
            end
        endcase
        if (wake_i) begin
            state_d = HPPAD_SETTLE;
            sel_d = SEL_NONE;
        end
    end

    // sel_q has no writer but the detector; no host path reaches it
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= HPPAD_SETTLE;
            sel_q <= SEL_NONE; // [R1]
        end else if (clk_en_i) begin
            state_q <= state_d;
            sel_q <= sel_d; // [R2]
        end
    end

    // settling and window timers, edge counter
    // window timed on the fast block clock, so its end is finer than 74 ns
    wire logic in_settle = (state_q == HPPAD_SETTLE);
    wire logic in_win = (state_q == HPPAD_WINDOW);
    wire logic edge_cnt = in_win && clk_edge && (edges_q != EDGE_SAT);

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            settle_q <= '0;
            win_q <= WIN_ZERO;
            edges_q <= EDGE_NONE;
        end else if (clk_en_i) begin
            settle_q <= (in_settle && !settle_done && !wake_i) ?
                settle_q + 1'b1 : '0;
            win_q <= (in_win && !win_end) ? win_q + 1'b1 : WIN_ZERO;
            edges_q <= !in_win ? EDGE_NONE :
                edge_cnt ? edges_q + EDGE_ONE : edges_q;
        end
    end

    // pin routing; before a lock every pin stays an input
    wire logic m_spi = (sel_q == SEL_SPI);
    wire logic m_uart = (sel_q == SEL_UART);
    wire logic m_i2c = (sel_q == SEL_I2C);

    wire logic clk_out_d = m_uart && uart_txd_i; // [R4]
    wire logic hin_out_d = m_uart && uart_rts_b_i; // [R4]
    wire logic hout_out_d = m_spi && spi_miso_i; // [R4]
    // open drain SDA: drive only the low level
    wire logic hout_oe_d = m_spi || (m_i2c && i2c_sda_low_i); // [R4]

    // engines see idle levels unless their mode is locked, except the I2C address, which is never gated
    wire logic spi_sclk_d = m_spi ? sync_q[PIN_CLK] : 1'b0;
    wire logic spi_mosi_d = m_spi ? sync_q[PIN_HIN] : 1'b0;
    wire logic spi_cs_b_d = m_spi ? sync_q[PIN_SEL] : 1'b1;
    wire logic uart_rxd_d = m_uart ? sync_q[PIN_SEL] : 1'b1;
    wire logic uart_cts_d = m_uart ? sync_q[PIN_HOUT] : 1'b1;
    wire logic i2c_scl_d = m_i2c ? sync_q[PIN_CLK] : 1'b1;
    // the host in pin picks the I2C address in every mode, locked or not
    wire logic i2c_sda_d = m_i2c ? sync_q[PIN_HOUT] : 1'b1;
    wire logic [6:0] i2c_addr_d = sync_q[PIN_HIN] ?
        I2C_ADDR_ALT : I2C_ADDR_DEF; // [R5]

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            shared_clock_pin_o <= 1'b0;
            shared_clock_pin_oe_o <= 1'b0;
            shared_host_in_pin_o <= 1'b0;
            shared_host_in_pin_oe_o <= 1'b0;
            shared_host_out_pin_o <= 1'b0;
            shared_host_out_pin_oe_o <= 1'b0;
            shared_select_pin_o <= 1'b0;
            shared_select_pin_oe_o <= 1'b0;
            protocol_select_o <= SEL_NONE;
        end else if (clk_en_i) begin
            shared_clock_pin_o <= clk_out_d;
            shared_clock_pin_oe_o <= m_uart; // [R3] [R4]
            shared_host_in_pin_o <= hin_out_d;
            shared_host_in_pin_oe_o <= m_uart; // [R4]
            shared_host_out_pin_o <= hout_out_d;
            shared_host_out_pin_oe_o <= hout_oe_d; // [R3]
            shared_select_pin_o <= 1'b0;
            shared_select_pin_oe_o <= 1'b0;
            protocol_select_o <= sel_q; // [R1]
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            spi_sclk_o <= 1'b0;
            spi_mosi_o <= 1'b0;
            spi_cs_b_o <= 1'b1;
            uart_rxd_o <= 1'b1;
            uart_cts_b_o <= 1'b1;
            i2c_scl_o <= 1'b1;
            i2c_sda_o <= 1'b1;
            i2c_addr_o <= I2C_ADDR_DEF;
        end else if (clk_en_i) begin
            spi_sclk_o <= spi_sclk_d;
            spi_mosi_o <= spi_mosi_d;
            spi_cs_b_o <= spi_cs_b_d;
            uart_rxd_o <= uart_rxd_d;
            uart_cts_b_o <= uart_cts_d;
            i2c_scl_o <= i2c_scl_d;
            i2c_sda_o <= i2c_sda_d;
            i2c_addr_o <= i2c_addr_d; // [R5]
        end
    end

    // checks
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    AST_LOCK_CODE: assert property ( // [R1]
        state_q == HPPAD_LOCKED |-> sel_q != SEL_NONE)
        else $error("locked with no slave selected");

    AST_SEL_HOLD: assert property ( // [R2]
        state_q == HPPAD_LOCKED && !wake_i |=> $stable(sel_q))
        else $error("select changed while locked");

    AST_SETTLE_QUIET: assert property ( // [R6]
        state_q == HPPAD_SETTLE |-> sel_q == SEL_NONE
            && !hout_oe_d ##0 settle_q <= SETTLE_LAST)
        else $error("activity during settling");

    AST_I2C_START: assert property ( // [R7]
        clk_en_i && !wake_i && state_q == HPPAD_WATCH && i2c_start
        |=> state_q == HPPAD_LOCKED && sel_q == SEL_I2C)
        else $error("i2c start not detected");

    AST_WIN_ENTER: assert property ( // [R8]
        clk_en_i && !wake_i && state_q == HPPAD_WATCH && !i2c_start
        && sel_fall |=> in_win && win_q == WIN_ZERO && edges_q == EDGE_NONE)
        else $error("select fall did not open window");

    AST_WIN_LEN: assert property ( // [R9]
        in_win |-> win_q <= WIN_LAST)
        else $error("window overran");

    AST_SPI: assert property ( // [R10]
        clk_en_i && !wake_i && in_win && win_end && edges_q > 3'h2
        |=> sel_q == SEL_SPI ##1 !clk_en_i || shared_host_out_pin_oe_o)
        else $error("spi not selected");

    AST_UART: assert property ( // [R11]
        clk_en_i && !wake_i && in_win && win_end && edges_q == EDGE_NONE
        |=> sel_q == SEL_UART ##1 !clk_en_i || shared_clock_pin_oe_o)
        else $error("uart not selected");

    AST_AMBIG: assert property ( // [R17]
        clk_en_i && !wake_i && in_win && win_end
        && edges_q inside {3'h1, 3'h2}
        |=> state_q == HPPAD_WATCH && sel_q == SEL_NONE)
        else $error("ambiguous count not rejected");

    AST_I2C_ADDR: assert property ( // [R5]
        clk_en_i && sync_q[PIN_HIN]
        |=> !clk_en_i || i2c_addr_o == I2C_ADDR_ALT)
        else $error("alternate address not used");

    AST_SEL_OUT: assert property ( // [R1]
        clk_en_i |=> protocol_select_o == $past(sel_q))
        else $error("select output does not follow detector");

    AST_SDA_OPEN: assert property ( // [R4]
        clk_en_i && m_i2c |=> !shared_host_out_pin_o)
        else $error("sda driven high in i2c mode");

    AST_WAKE: assert property ( // [R18]
        clk_en_i && wake_i
        |=> in_settle && sel_q == SEL_NONE && settle_q == '0)
        else $error("wake did not restart detection");

    AST_SETTLE_LEN: assert property ( // [R6]
        clk_en_i && !wake_i && in_settle && !settle_done
        |=> in_settle)
        else $error("settling left early");

endmodule

`default_nettype wire

/* core/hppad_pkg.sv */
// constants, codes and state type of the host port protocol autodetector
// assumes one 250 MHz block clock samples every shared host pin
// Behaviour
// R1: select code is 00 I2C, 01 SPI, 10 UART, 11 none selected.
// R2: host cannot write the select bits; only the detector changes them.
// R3: on detection the select bits are set and shared pins enabled for it.
// R4: each mode routes the four shared pins with its own directions.
// R5: I2C answers address 0x44, or 0x46 when alternate select pin is high.
// R6: after reset pin activity is ignored until a 1 ms settling timer ends.
// R7: after settling, SDA falling while SCL high selects I2C.
// R8: after settling, select/RXD pin falling enters the UART-or-SPI state.
// R9: UART-or-SPI state counts clock pin edges over a 3 us window.
// R10: more than two edges at window end selects SPI.
// R11: no edges at window end selects UART.
// R12: SPI or UART host resends its first command after power-up or wake.
// R13: SPI host starts each transaction by pulling select low on a clock edge.
// R14: UART host starts each transaction with a 1 us start bit at 1 Mbps.
// R15: host drives shared pins to protocol idle levels before reset release.
// R16: detector timing runs in the host interface clock domain; here it runs on the 250 MHz block clock ref_clk_i.
// R17: one or two edges leaves no slave selected and resumes waiting.
// R18: a selection holds until reset or wake, ignoring other start patterns.
`default_nettype none

package hppad_pkg;

    // block clock
    localparam int unsigned CLK_PERIOD_NS = 4;

    // settling time after reset, least time so rounded up
    localparam int unsigned SETTLE_TIME_NS = 1_000_000;
    localparam int unsigned SETTLE_CYC =
        (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SETTLE_W = 20;

    // edge counting window, longest time so rounded down
    localparam int unsigned WIN_TIME_NS = 3_000;
    localparam int unsigned WIN_CYC = WIN_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned WIN_W = 10;
    localparam logic [WIN_W-1:0] WIN_ZERO = 10'h000;
    localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(WIN_CYC - 1);

    // clock pin edge counter, saturating
    localparam int unsigned EDGE_W = 3;
    localparam logic [EDGE_W-1:0] EDGE_NONE = 3'h0;
    localparam logic [EDGE_W-1:0] EDGE_ONE = 3'h1;
    localparam logic [EDGE_W-1:0] EDGE_SPI_MIN = 3'h3;
    localparam logic [EDGE_W-1:0] EDGE_SAT = 3'h7;

    // shared pin indices in the sampled vector
    localparam int unsigned PIN_N = 4;
    localparam int unsigned PIN_CLK = 0;
    localparam int unsigned PIN_HIN = 1;
    localparam int unsigned PIN_HOUT = 2;
    localparam int unsigned PIN_SEL = 3;
    localparam logic [PIN_N-1:0] PIN_IDLE = 4'hF;

    // protocol select codes
    typedef logic [1:0] hppad_sel_t;
    localparam hppad_sel_t SEL_I2C = 2'h0;
    localparam hppad_sel_t SEL_SPI = 2'h1;
    localparam hppad_sel_t SEL_UART = 2'h2;
    localparam hppad_sel_t SEL_NONE = 2'h3;

    // I2C slave addresses, 7 bit
    localparam logic [6:0] I2C_ADDR_DEF = 7'h44;
    localparam logic [6:0] I2C_ADDR_ALT = 7'h46;

    // detector states, gray along settle, watch, window, locked
    typedef enum logic [1:0] {
        HPPAD_SETTLE = 2'h0,
        HPPAD_WATCH = 2'h1,
        HPPAD_WINDOW = 2'h3,
        HPPAD_LOCKED = 2'h2
    } hppad_state_e;

endpackage

`default_nettype wire

/* dv/hppad_host_model.sv */
// host processor model driving the four shared pins of the autodetector
// assumes the bench resolves each pad from these levels and the block's oe
`default_nettype none

module hppad_host_model (
    // pad levels offered by the host
    output logic clk_o,
    output logic hin_o,
    output logic sda_low_o,
    output logic sel_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import hppad_pkg::*;

    // idle levels, set while the block is held in reset or settling
    task automatic idle(input hppad_sel_t mode, input logic alt);
        clk_o = (mode == SEL_I2C);
        hin_o = (mode == SEL_I2C) ? alt : 1'b0;
        sda_low_o = 1'b0;
        sel_o = 1'b1;
    endtask

    // start then stop, sda open drain so only a pull low is offered
    task automatic i2c_start();
        sda_low_o = 1'b1;
        #500 clk_o = 1'b0;
        #500 clk_o = 1'b1;
        #500 sda_low_o = 1'b0;
    endtask

    // link clock of 48 ns, stands still outside the frame
    task automatic spi_frame(input int edges);
        #24 sel_o = 1'b0;
        repeat (edges) #24 clk_o = ~clk_o;
        #24 sel_o = 1'b1;
    endtask

    // 1 us bits at 1 Mbps, lsb first, start low and stop high
    task automatic uart_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            sel_o = f[i];
            #1000;
        end
    endtask
endmodule

`default_nettype wire

/* dv/test_hppad_autodetect.sv */
// self-checking bench of the host port protocol autodetector
// assumes the host model on the pads and random engine levels behind
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

module test_hppad_autodetect;
    timeunit 1ns;
    timeprecision 1ps;
    import hppad_pkg::*;

    // small settle count keeps the run short
    localparam int SETTLE = 16;
    logic ref_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic wake_i = 1'b0;
    logic spi_miso_i = 1'b0;
    logic uart_txd_i = 1'b1;
    logic uart_rts_b_i = 1'b1;
    logic i2c_sda_low_i = 1'b0;
    logic shared_clock_pin_i, shared_clock_pin_o, shared_clock_pin_oe_o;
    logic shared_host_in_pin_i, shared_host_in_pin_o, shared_host_in_pin_oe_o;
    logic shared_host_out_pin_i, shared_host_out_pin_o;
    logic shared_host_out_pin_oe_o;
    logic shared_select_pin_i, shared_select_pin_o, shared_select_pin_oe_o;
    logic spi_sclk_o, spi_mosi_o, spi_cs_b_o, uart_rxd_o, uart_cts_b_o;
    logic i2c_scl_o, i2c_sda_o;
    logic [6:0] i2c_addr_o;
    hppad_sel_t protocol_select_o;
    logic h_clk, h_hin, h_sda, h_sel;
    int err_total = 0;
    int checked = 0;
    hppad_sel_t exp_q[$];
    hppad_sel_t last_sel = 2'bxx;
    hppad_sel_t mon_exp;
    logic [7:0] lfsr = 8'h4D;

    // pad levels: the block wins where its oe is high, sda is open drain
    assign shared_clock_pin_i = shared_clock_pin_oe_o ? shared_clock_pin_o
                                                      : h_clk;
    assign shared_host_in_pin_i = shared_host_in_pin_oe_o ?
                                  shared_host_in_pin_o : h_hin;
    assign shared_host_out_pin_i = shared_host_out_pin_oe_o ?
        (shared_host_out_pin_o & ~h_sda) : ~h_sda;
    assign shared_select_pin_i = shared_select_pin_oe_o ?
                                 shared_select_pin_o : h_sel;

    hppad_autodetect #(.SETTLE_CYCLES(SETTLE)) dut (
        .ref_clk_i, .rst_b_i, .clk_en_i, .wake_i,
        .shared_clock_pin_i, .shared_clock_pin_o, .shared_clock_pin_oe_o,
        .shared_host_in_pin_i, .shared_host_in_pin_o,
        .shared_host_in_pin_oe_o, .shared_host_out_pin_i,
        .shared_host_out_pin_o, .shared_host_out_pin_oe_o,
        .shared_select_pin_i, .shared_select_pin_o, .shared_select_pin_oe_o,
        .protocol_select_o, .spi_sclk_o, .spi_mosi_o, .spi_cs_b_o,
        .spi_miso_i, .uart_rxd_o, .uart_cts_b_o, .uart_txd_i, .uart_rts_b_i,
        .i2c_scl_o, .i2c_sda_o, .i2c_addr_o, .i2c_sda_low_i
    );

    hppad_host_model host (
        .clk_o(h_clk), .hin_o(h_hin), .sda_low_o(h_sda), .sel_o(h_sel)
    );

    initial begin
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    // every change of the select code takes the oldest note
    always @(negedge ref_clk_i) begin
        if (protocol_select_o !== last_sel) begin
            last_sel = protocol_select_o;
            mon_exp = exp_q.size() ? exp_q.pop_front() : 2'bxx;
            `CHK("select", mon_exp, protocol_select_o)
        end
    end

    task automatic do_reset(input hppad_sel_t mode, input logic alt);
        if (protocol_select_o !== SEL_NONE) exp_q.push_back(SEL_NONE);
        rst_b_i = 1'b0;
        host.idle(mode, alt);
        repeat (3) @(negedge ref_clk_i);
        rst_b_i = 1'b1;
    endtask

    task automatic settle();
        repeat (SETTLE + 4) @(negedge ref_clk_i);
    endtask

    task automatic wait_lock();
        int n;
        n = 0;
        while (protocol_select_o === SEL_NONE && n < 1000) begin
            @(negedge ref_clk_i);
            n++;
        end
        `CHK("lock", 1'b1, n < 1000)
    endtask

    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    // random engine levels must reach the pads of the locked mode only
    task automatic route(input hppad_sel_t m, input logic alt);
        logic e_out;
        repeat (2) begin
            lfsr = lfsr_next(lfsr);
            spi_miso_i = lfsr[3];
            uart_txd_i = lfsr[2];
            uart_rts_b_i = lfsr[1];
            i2c_sda_low_i = lfsr[0];
            // sda loops back through oe, pad and synchroniser: four edges
            repeat (5) @(negedge ref_clk_i);
            e_out = (m == SEL_SPI) | ((m == SEL_I2C) & i2c_sda_low_i);
            `CHK("clk_oe", m == SEL_UART, shared_clock_pin_oe_o)
            `CHK("hin_oe", m == SEL_UART, shared_host_in_pin_oe_o)
            `CHK("hout_oe", e_out, shared_host_out_pin_oe_o)
            `CHK("sel_oe", 1'b0, shared_select_pin_oe_o)
            `CHK("sel_out", 1'b0, shared_select_pin_o)
            if (m == SEL_UART) begin
                `CHK("txd", uart_txd_i, shared_clock_pin_o)
                `CHK("rts", uart_rts_b_i, shared_host_in_pin_o)
                `CHK("rxd", shared_select_pin_i, uart_rxd_o)
                `CHK("cts", shared_host_out_pin_i, uart_cts_b_o)
            end else if (m == SEL_SPI) begin
                `CHK("miso", spi_miso_i, shared_host_out_pin_o)
                `CHK("sclk", shared_clock_pin_i, spi_sclk_o)
                `CHK("cs", shared_select_pin_i, spi_cs_b_o)
                `CHK("mosi", shared_host_in_pin_i, spi_mosi_o)
            end else begin
                `CHK("addr", alt ? 7'h46 : 7'h44, i2c_addr_o)
                `CHK("scl", shared_clock_pin_i, i2c_scl_o)
                `CHK("sda", shared_host_out_pin_i, i2c_sda_o)
            end
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #200_000;
        err_total++;
        print_verdict();
    end

    initial begin
        for (int a = 0; a < 2; a++) begin
            do_reset(SEL_I2C, a[0]);
            // start patterns inside the settling time must be ignored
            {host.sel_o, host.sda_low_o} = 2'b01;
            repeat (4) @(negedge ref_clk_i);
            {host.sel_o, host.sda_low_o} = 2'b10;
            settle();
            `CHK("settled", SEL_NONE, protocol_select_o)
            exp_q.push_back(SEL_I2C);
            host.i2c_start();
            wait_lock();
            route(SEL_I2C, a[0]);
            host.uart_byte(8'h41);
        end
        do_reset(SEL_SPI, 1'b0);
        settle();
        exp_q.push_back(SEL_SPI);
        host.spi_frame(3);
        wait_lock();
        route(SEL_SPI, 1'b0);
        host.spi_frame(16);
        do_reset(SEL_UART, 1'b0);
        settle();
        host.spi_frame(2);
        repeat (800) @(negedge ref_clk_i);
        `CHK("two edges", SEL_NONE, protocol_select_o)
        exp_q.push_back(SEL_UART);
        host.uart_byte(8'h5A);
        wait_lock();
        route(SEL_UART, 1'b0);
        host.uart_byte(8'h5A);
        // a wake while the enable is low must be refused
        clk_en_i = 1'b0;
        wake_i = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        wake_i = 1'b0;
        clk_en_i = 1'b1;
        @(negedge ref_clk_i);
        `CHK("frozen", SEL_UART, protocol_select_o)
        exp_q.push_back(SEL_NONE);
        wake_i = 1'b1;
        @(negedge ref_clk_i);
        wake_i = 1'b0;
        host.idle(SEL_I2C, 1'b1);
        settle();
        exp_q.push_back(SEL_I2C);
        host.i2c_start();
        wait_lock();
        route(SEL_I2C, 1'b1);
        `CHK("notes left", 0, exp_q.size())
        print_verdict();
    end
endmodule

`default_nettype wire
